// ===== core/derb_defs.vh
// Constants for the external register bus and pin block.
`ifndef DERB_DEFS_VH
`define DERB_DEFS_VH
// --------------------
// Register byte offsets
// --------------------
`define DERB_OFS_CTRL 8'h00
`define DERB_OFS_STAT 8'h04
`define DERB_OFS_P0DIR 8'h08
`define DERB_OFS_P0OUT 8'h0c
`define DERB_OFS_P0IN 8'h10
`define DERB_OFS_P1 8'h14
`define DERB_OFS_EDGE 8'h18
`define DERB_OFS_P2FN 8'h1c
`define DERB_OFS_P2 8'h20
`define DERB_OFS_P2IN 8'h24
`define DERB_OFS_P3 8'h28
// --------------------
// Control register fields
// --------------------
`define DERB_CTRL_WS 0
`define DERB_CTRL_UOEN 1
`define DERB_CTRL_TMA 2
`define DERB_CTRL_TMB 3
`define DERB_CTRL_P0EN 4
`define DERB_CTRL_P0OD 5
`define DERB_CTRL_P0HI 6
`define DERB_CTRL_RST 7'h00
// --------------------
// Status bits, port two functions, timing, vectors
// --------------------
`define DERB_ST_UOA 5
`define DERB_ST_UOB 6
`define DERB_FN_IRQ0 0
`define DERB_FN_IRQ1 1
`define DERB_FN_TMA 2
`define DERB_FN_TMB 3
`define DERB_FN_WAIT 4
`define DERB_FN_TM2 6
`define DERB_STB_MIN 2'd2
`define DERB_RST_VEC 12'hffc
`define DERB_RESP_OK 2'b00
`define DERB_RESP_ERR 2'b10
`endif

// ===== core/derb_pins.v
// External register bus, halt and reset pins, user I/O and port pins of the DSP core.
//
// Summary of operation
// - Address outputs are driven on every external-register access, internal or external.
// - Three address lines select seven user registers; the eighth slot is reserved.
// - Data lines float except during external writes or enabled wide-port outputs.
// - The data strobe is asserted only for transfers to or from external peripherals.
// - Write data is on the data lines while select and strobe are both low.
// - The wait input is sampled on the rising clock edge to extend a transfer.
// - One internal wait state is inserted when the configuration bit is set.
// - While halt is low the core executes no-ops and the counter stays constant.
// - Reset pushes the counter; after release the counter loads from address 0ffc.
// - Reset clears every status register bit.
// - Other registers keep their contents across later resets.
// - The reset pin may be asserted at any moment, unaligned to the clock.
// - Each of three interrupt pins triggers on a selectable rising or falling edge.
// - Two user inputs feed branch tests and read as status bits.
// - With user outputs on and timer off, output b drives inverted status bit 6.
// - The wide port uses all 16 data lines, per-bit direction, global open drain.
// - Wide port function changes on register writes; its high byte may go to port one.
// - A port-two function takes its pin from general use for the lower seven pins.
// - Third port: upper four pins are outputs only, lower four inputs only.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "derb_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module derb_pins (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire core_req,
    input wire core_we,
    input wire core_int,
    input wire [2:0] core_addr,
    input wire [15:0] core_wdata,
    output reg [15:0] core_rdata,
    output reg core_done,
    output reg core_busy,
    output reg core_nop_hold,
    output reg pc_push,
    output reg pc_load,
    output reg [11:0] pc_vector,
    output reg [1:0] user_in,
    output reg [2:0] ext_irq_evt,
    input wire timer_a_out,
    input wire timer_b_out,
    input wire timer_c_out,
    output reg [2:0] ext_reg_addr,
    output reg data_strobe_n,
    output reg rd_wr_n,
    input wire [15:0] ext_reg_data_i,
    output reg [15:0] ext_reg_data_o,
    output reg [15:0] ext_reg_data_oe_n,
    input wire halt_n,
    input wire reset_pin_n,
    input wire ext_irq2_pin,
    input wire user_input_a,
    input wire user_input_b,
    output reg timer_or_user_out_a,
    output reg timer_or_user_out_b,
    input wire [7:0] byte_port_b_i,
    output reg [7:0] byte_port_b_o,
    output reg [7:0] byte_port_b_oe_n,
    input wire [3:0] split_dir_port_i,
    output reg [3:0] split_dir_port_o
);

    // --------------------
    // Declarations
    // --------------------
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SET = 4'b0010;
    localparam [3:0] S_STB = 4'b0100;
    localparam [3:0] S_END = 4'b1000;

    reg [15:0] ed_s1_r, ed_s2_r;
    reg [7:0] p2_s1_r, p2_s2_r;
    reg [3:0] p3_s1_r, p3_s2_r;
    reg [5:0] misc_s1_r, misc_s2_r;
    reg [2:0] irq_d_r;
    reg rst_d_r;

    reg [6:0] ctrl_r;
    reg [1:0] uo_r;
    reg [15:0] p0_dir_r, p0_out_r, p1_r, p2_r;
    reg [2:0] edge_r;
    reg [6:0] p2_fn_r;
    reg [3:0] p3_out_r;

    reg [3:0] state_r, state_nxt;
    reg [1:0] cnt_r, cnt_nxt;
    reg [2:0] addr_nxt;
    reg stb_n_nxt, rw_nxt, done_nxt;
    reg wr_r, wr_nxt;
    reg [15:0] wdat_r, wdat_nxt, rdat_nxt;

    reg [7:0] awaddr_r;
    reg aw_got_r, w_got_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg [31:0] rd_nxt;
    reg rd_hit;
    reg wr_hit;

    wire halt_s = misc_s2_r[0];
    wire rst_s = misc_s2_r[1];
    wire [1:0] ui_s = misc_s2_r[3:2];
    wire irq2_s = misc_s2_r[4];
    wire wait_act = p2_fn_r[`DERB_FN_WAIT] & ~p2_s2_r[`DERB_FN_WAIT];
    wire [2:0] irq_s = {irq2_s, p2_s2_r[1:0]};
    wire do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire [15:0] st_val = {9'h000, uo_r, 2'b00, ~state_r[0], ui_s};

    // Byte-lane merge of a 16-bit field.
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
        end
    endfunction

    // --------------------
    // Pin synchronisers
    // --------------------
    // Every pin input passes two flops; the reset pin may fall at any time.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ed_s1_r <= 16'h0000;
            ed_s2_r <= 16'h0000;
            p2_s1_r <= 8'hff;
            p2_s2_r <= 8'hff;
            p3_s1_r <= 4'h0;
            p3_s2_r <= 4'h0;
            misc_s1_r <= 6'h03;
            misc_s2_r <= 6'h03;
        end else begin
            ed_s1_r <= ext_reg_data_i;
            ed_s2_r <= ed_s1_r;
            p2_s1_r <= byte_port_b_i;
            p2_s2_r <= p2_s1_r;
            p3_s1_r <= split_dir_port_i;
            p3_s2_r <= p3_s1_r;
            misc_s1_r <= {1'b0, ext_irq2_pin, user_input_b, user_input_a, reset_pin_n, halt_n};
            misc_s2_r <= misc_s1_r;
        end
    end

    // --------------------
    // Halt, reset pin, user inputs and interrupt edges
    // --------------------
    // Core-side pulses and levels derived from the synchronised pins.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rst_d_r <= 1'b1;
            irq_d_r <= 3'h0;
            core_nop_hold <= 1'b0;
            pc_push <= 1'b0;
            pc_load <= 1'b0;
            pc_vector <= `DERB_RST_VEC;
            user_in <= 2'b00;
            ext_irq_evt <= 3'h0;
        end else begin
            rst_d_r <= rst_s;
            irq_d_r <= irq_s;
            core_nop_hold <= ~halt_s;
            pc_push <= rst_d_r & ~rst_s;
            pc_load <= ~rst_d_r & rst_s;
            pc_vector <= `DERB_RST_VEC;
            user_in <= ui_s;
            ext_irq_evt <= (edge_r & irq_s & ~irq_d_r) | (~edge_r & ~irq_s & irq_d_r);
        end
    end

    // --------------------
    // External bus sequencer
    // --------------------
    // Address setup, strobe with minimum width, wait extension, release.
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = ext_reg_addr;
        stb_n_nxt = 1'b1;
        rw_nxt = rd_wr_n;
        wr_nxt = wr_r;
        wdat_nxt = wdat_r;
        rdat_nxt = core_rdata;
        done_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                rw_nxt = 1'b1;
                wr_nxt = 1'b0;
                if (core_req) begin
                    addr_nxt = core_addr;
                    wdat_nxt = core_wdata;
                    if (core_int) begin
                        state_nxt = S_END;
                    end else begin
                        rw_nxt = ~core_we;
                        wr_nxt = core_we;
                        state_nxt = S_SET;
                    end
                end
            end
            S_SET: begin
                stb_n_nxt = 1'b0;
                cnt_nxt = ctrl_r[`DERB_CTRL_WS] ? `DERB_STB_MIN + 2'd1 : `DERB_STB_MIN;
                state_nxt = S_STB;
            end
            S_STB: begin
                stb_n_nxt = 1'b0;
                if (cnt_r != 2'd0) begin
                    cnt_nxt = cnt_r - 2'd1;
                end else if (!wait_act) begin
                    stb_n_nxt = 1'b1;
                    rdat_nxt = ed_s2_r;
                    state_nxt = S_END;
                end
            end
            S_END: begin
                rw_nxt = 1'b1;
                wr_nxt = 1'b0;
                done_nxt = 1'b1;
                state_nxt = S_IDLE;
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // Sequencer registers; the pins come straight from these flops.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE;
            cnt_r <= 2'd0;
            ext_reg_addr <= 3'h0;
            data_strobe_n <= 1'b1;
            rd_wr_n <= 1'b1;
            wr_r <= 1'b0;
            wdat_r <= 16'h0000;
            core_rdata <= 16'h0000;
            core_done <= 1'b0;
            core_busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ext_reg_addr <= addr_nxt;
            data_strobe_n <= stb_n_nxt;
            rd_wr_n <= rw_nxt;
            wr_r <= wr_nxt;
            wdat_r <= wdat_nxt;
            core_rdata <= rdat_nxt;
            core_done <= done_nxt;
            core_busy <= ~state_nxt[0];
        end
    end

    // --------------------
    // Data lines, port pins and user outputs
    // --------------------
    // Bus writes own the data lines; otherwise the wide port may drive them.
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_ed
            wire hi = (i > 7) && ctrl_r[`DERB_CTRL_P0HI];
            wire pdir = hi ? p1_r[i % 8] : p0_dir_r[i];
            wire pout = hi ? p1_r[i] : p0_out_r[i];
            wire pdrv = ctrl_r[`DERB_CTRL_P0EN] & pdir & ~(ctrl_r[`DERB_CTRL_P0OD] & pout);
            always @(posedge aclk) begin
                if (!aresetn) begin
                    ext_reg_data_o[i] <= 1'b0;
                    ext_reg_data_oe_n[i] <= 1'b1;
                end else begin
                    ext_reg_data_o[i] <= wr_nxt ? wdat_nxt[i] : pout;
                    ext_reg_data_oe_n[i] <= ~(wr_nxt | pdrv);
                end
            end
        end
        for (i = 0; i < 8; i = i + 1) begin : g_p2
            wire fn = (i < 7) && p2_fn_r[i % 7];
            wire fo = (i == `DERB_FN_TMA) ? timer_or_user_out_a :
                      (i == `DERB_FN_TMB) ? timer_or_user_out_b : timer_c_out;
            wire fdrv = (i == `DERB_FN_TMA) || (i == `DERB_FN_TMB) || (i == `DERB_FN_TM2);
            always @(posedge aclk) begin
                if (!aresetn) begin
                    byte_port_b_o[i] <= 1'b0;
                    byte_port_b_oe_n[i] <= 1'b1;
                end else begin
                    byte_port_b_o[i] <= fn ? fo : p2_r[i + 8];
                    byte_port_b_oe_n[i] <= fn ? ~fdrv : ~p2_r[i];
                end
            end
        end
    endgenerate

    // Timer or inverted status bit on the two shared outputs; port three outputs.
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_or_user_out_a <= 1'b1;
            timer_or_user_out_b <= 1'b1;
            split_dir_port_o <= 4'h0;
        end else begin
            timer_or_user_out_a <= (ctrl_r[`DERB_CTRL_UOEN] & ~ctrl_r[`DERB_CTRL_TMA]) ?
                                   ~uo_r[0] : timer_a_out;
            timer_or_user_out_b <= (ctrl_r[`DERB_CTRL_UOEN] & ~ctrl_r[`DERB_CTRL_TMB]) ?
                                   ~uo_r[1] : timer_b_out;
            split_dir_port_o <= p3_out_r;
        end
    end

    // --------------------
    // AXI4-Lite write channel
    // --------------------
    // Address and data are caught in either order, then the write and response follow.
    always @* begin
        case (awaddr_r)
            `DERB_OFS_CTRL, `DERB_OFS_STAT, `DERB_OFS_P0DIR, `DERB_OFS_P0OUT, `DERB_OFS_P1,
            `DERB_OFS_EDGE, `DERB_OFS_P2FN, `DERB_OFS_P2, `DERB_OFS_P3: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write handshake and register updates.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DERB_RESP_OK;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            ctrl_r <= `DERB_CTRL_RST;
            uo_r <= 2'b00;
            p0_dir_r <= 16'h0000;
            p0_out_r <= 16'h0000;
            p1_r <= 16'h0000;
            edge_r <= 3'h0;
            p2_fn_r <= 7'h00;
            p2_r <= 16'h0000;
            p3_out_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `DERB_RESP_OK : `DERB_RESP_ERR;
                if (wstrb_r[0]) begin
                    case (awaddr_r)
                        `DERB_OFS_CTRL: ctrl_r <= wdata_r[6:0];
                        `DERB_OFS_STAT: uo_r <= wdata_r[6:5];
                        `DERB_OFS_EDGE: edge_r <= wdata_r[2:0];
                        `DERB_OFS_P2FN: p2_fn_r <= wdata_r[6:0];
                        `DERB_OFS_P3: p3_out_r <= wdata_r[7:4];
                        default: ;
                    endcase
                end
                case (awaddr_r)
                    `DERB_OFS_P0DIR: p0_dir_r <= merge16(p0_dir_r, wdata_r, wstrb_r);
                    `DERB_OFS_P0OUT: p0_out_r <= merge16(p0_out_r, wdata_r, wstrb_r);
                    `DERB_OFS_P1: p1_r <= merge16(p1_r, wdata_r, wstrb_r);
                    `DERB_OFS_P2: p2_r <= merge16(p2_r, wdata_r, wstrb_r);
                    default: ;
                endcase
            end
            if (!rst_s) begin
                uo_r <= 2'b00;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // --------------------
    // AXI4-Lite read channel
    // --------------------
    // Read data selection; unmapped offsets answer with an error and zero.
    always @* begin
        rd_nxt = 32'h00000000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `DERB_OFS_CTRL: rd_nxt[6:0] = ctrl_r;
            `DERB_OFS_STAT: rd_nxt[15:0] = rst_s ? st_val : 16'h0000;
            `DERB_OFS_P0DIR: rd_nxt[15:0] = p0_dir_r;
            `DERB_OFS_P0OUT: rd_nxt[15:0] = p0_out_r;
            `DERB_OFS_P0IN: rd_nxt[15:0] = ed_s2_r;
            `DERB_OFS_P1: rd_nxt[15:0] = p1_r;
            `DERB_OFS_EDGE: rd_nxt[2:0] = edge_r;
            `DERB_OFS_P2FN: rd_nxt[6:0] = p2_fn_r;
            `DERB_OFS_P2: rd_nxt[15:0] = p2_r;
            `DERB_OFS_P2IN: rd_nxt[7:0] = p2_s2_r;
            `DERB_OFS_P3: rd_nxt[7:0] = {p3_out_r, p3_s2_r};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read handshake: one read in flight, answered the cycle after acceptance.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DERB_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_nxt;
                s_axi_rresp <= rd_hit ? `DERB_RESP_OK : `DERB_RESP_ERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/derb_periph.sv
// Model of the user peripheral registers on the external bus.
`timescale 1ns/1ps
`default_nettype none
module derb_periph (
    input wire logic aclk,
    input wire logic [2:0] ext_reg_addr,
    input wire logic data_strobe_n,
    input wire logic rd_wr_n,
    input wire logic [15:0] ext_reg_data_o,
    input wire logic [15:0] ext_reg_data_oe_n,
    input wire logic [3:0] wait_len,
    output logic [15:0] ext_reg_data_i,
    output logic wait_n
);
    logic [15:0] regs [0:7];
    logic [15:0] last = 16'h0000;
    logic [3:0] wcnt = 4'h0;
    logic stb_q = 1'b1;
    // Line level: device drive, else read data, else a value that keeps moving.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!ext_reg_data_oe_n[i])
                ext_reg_data_i[i] = ext_reg_data_o[i];
            else if (!data_strobe_n && rd_wr_n)
                ext_reg_data_i[i] = regs[ext_reg_addr][i];
            else
                ext_reg_data_i[i] = ~last[i];
        end
    end
    // Latch writes; pull wait low from the first strobe cycle, as the device sees it late.
    always @(posedge aclk) begin
        last <= ext_reg_data_i;
        stb_q <= data_strobe_n;
        if (!data_strobe_n && !rd_wr_n)
            regs[ext_reg_addr] <= ext_reg_data_i;
        if (stb_q && !data_strobe_n)
            wcnt <= wait_len;
        else if (wcnt != 4'h0)
            wcnt <= wcnt - 4'h1;
    end
    assign wait_n = (wcnt == 4'h0) && !(stb_q && !data_strobe_n && wait_len != 4'h0);
endmodule
`default_nettype wire

// ===== tb/derb_pins_bench.sv
// Self-checking bench for the external register bus pins.
`timescale 1ns/1ps
`default_nettype none
`include "derb_defs.vh"
module derb_pins_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic core_req, core_we, core_int, timer_a_out, timer_b_out, timer_c_out, halt_n, reset_pin_n;
    logic ext_irq2_pin, user_input_a, user_input_b, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, core_done, core_busy, core_nop_hold, pc_push, pc_load;
    logic data_strobe_n, rd_wr_n, timer_or_user_out_a, timer_or_user_out_b, wait_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, user_in, r;
    logic [2:0] core_addr, ext_irq_evt, ext_reg_addr;
    logic [3:0] s_axi_wstrb, split_dir_port_i, split_dir_port_o, wait_len;
    logic [7:0] s_axi_awaddr, s_axi_araddr, byte_port_b_o, byte_port_b_oe_n;
    logic [11:0] pc_vector;
    logic [15:0] core_wdata, core_rdata, ext_reg_data_i, ext_reg_data_o, ext_reg_data_oe_n, d;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [7:0] byte_port_b_i = {3'h0, wait_n, 4'h0};
    int error_cnt, compares, cyc, n;
    derb_pins uut (.*);
    derb_periph pm (.*);
    always #12.5 aclk = ~aclk;
    // --------------------
    // Access tasks
    // --------------------
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Address and data offered together, each dropped when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        logic ad = 1'b0, dd = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, wd, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad = ad | (s_axi_awready === 1'b1);
            dd = dd | (s_axi_wready === 1'b1);
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !dd;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask
    // One core access; k counts edges from the taking edge to the done pulse.
    task automatic core_op(input logic we, it, input logic [2:0] a, input logic [15:0] wd, output int k);
        @(posedge aclk);
        {core_req, core_we, core_int, core_addr, core_wdata} <= {1'b1, we, it, a, wd};
        @(posedge aclk);
        core_req <= 1'b0;
        k = 0;
        do begin
            @(posedge aclk);
            #1;
            k++;
        end while (core_done !== 1'b1 && k < 40);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Cut a hung run short.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // --------------------
    // Test sequence
    // --------------------
    initial begin
        {aclk, aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, core_req, core_we, core_int} = '0;
        {core_addr, core_wdata, timer_a_out, timer_b_out, timer_c_out, ext_irq2_pin} = '0;
        {user_input_a, user_input_b, split_dir_port_i, wait_len, halt_n, reset_pin_n} = 12'h003;
        tick(5);
        chk(data_strobe_n, 1'b1);
        chk(ext_reg_data_oe_n, 16'hffff);
        chk(pc_vector, `DERB_RST_VEC);
        aresetn <= 1'b1;
        rd_chk(`DERB_OFS_STAT, 32'h0, `DERB_RESP_OK);
        rd_chk(8'h3c, 32'h0, `DERB_RESP_ERR);
        axi_wr(8'h3c, 32'h1, r);
        chk(r, `DERB_RESP_ERR);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            axi_wr(`DERB_OFS_CTRL, i, r);
            d = i ? 16'h5a3c : 16'ha5c3;
            core_op(1'b1, 1'b0, 3'(6 - 5 * i), d, n);
            chk(n, 5 + i);
            core_op(1'b0, 1'b0, 3'(6 - 5 * i), 16'h0000, n);
            chk(core_rdata, d);
            chk(n, 5 + i);
        end
        core_op(1'b1, 1'b1, 3'h2, 16'h1111, n);
        chk(n, 1);
        chk(ext_reg_addr, 3'h2);
        $display("test bus done");
        axi_wr(`DERB_OFS_CTRL, 32'h0, r);
        axi_wr(`DERB_OFS_P2FN, 32'h1c, r);
        wait_len <= 4'h4;
        core_op(1'b1, 1'b0, 3'h3, 16'h0f0f, n);
        chk(n > 6 && n < 16, 1'b1);
        chk(byte_port_b_oe_n, 8'hf3);
        wait_len <= 4'h0;
        $display("test wait done");
        axi_wr(`DERB_OFS_CTRL, 32'h02, r);
        {user_input_a, user_input_b} <= 2'h3;
        for (int i = 0; i < 4; i++) begin
            axi_wr(`DERB_OFS_STAT, i << 5, r);
            tick(2);
            chk(timer_or_user_out_a, !i[0]);
            chk(timer_or_user_out_b, !i[1]);
        end
        chk(user_in, 2'h3);
        rd_chk(`DERB_OFS_STAT, 32'h63, `DERB_RESP_OK);
        $display("test user io done");
        reset_pin_n <= 1'b0;
        tick(6);
        rd_chk(`DERB_OFS_STAT, 32'h0, `DERB_RESP_OK);
        reset_pin_n <= 1'b1;
        tick(6);
        rd_chk(`DERB_OFS_STAT, 32'h03, `DERB_RESP_OK);
        rd_chk(`DERB_OFS_CTRL, 32'h02, `DERB_RESP_OK);
        halt_n <= 1'b0;
        tick(6);
        chk(core_nop_hold, 1'b1);
        halt_n <= 1'b1;
        tick(6);
        chk(core_nop_hold, 1'b0);
        $display("test reset pin and halt done");
        axi_wr(`DERB_OFS_CTRL, 32'h10, r);
        axi_wr(`DERB_OFS_P0DIR, 32'h00ff, r);
        axi_wr(`DERB_OFS_P0OUT, 32'h1234, r);
        axi_wr(`DERB_OFS_P3, 32'ha0, r);
        split_dir_port_i <= 4'h5;
        tick(4);
        chk(ext_reg_data_oe_n, 16'hff00);
        chk(ext_reg_data_o, 16'h1234);
        chk(split_dir_port_o, 4'ha);
        rd_chk(`DERB_OFS_P3, 32'ha5, `DERB_RESP_OK);
        $display("test ports done");
        for (int j = 0; j < 4; j++) begin
            axi_wr(`DERB_OFS_EDGE, j < 2 ? 32'h4 : 32'h0, r);
            ext_irq2_pin <= !j[0];
            n = 0;
            repeat (8) begin
                @(posedge aclk);
                n += (ext_irq_evt[2] === 1'b1);
            end
            chk(n, j[0] == j[1]);
        end
        $display("test interrupt pins done");
        tally_and_finish();
    end
endmodule
bind derb_pins derb_pins_chk chk (.*);
`default_nettype wire

// ===== tb/derb_pins_chk.sv
// Assertions on the external bus, halt and reset pins.
`timescale 1ns/1ps
`default_nettype none
module derb_pins_chk (
    input wire aclk,
    input wire aresetn,
    input wire core_req,
    input wire core_we,
    input wire core_int,
    input wire [2:0] core_addr,
    input wire core_busy,
    input wire core_done,
    input wire core_nop_hold,
    input wire pc_push,
    input wire pc_load,
    input wire [2:0] ext_reg_addr,
    input wire data_strobe_n,
    input wire rd_wr_n,
    input wire [15:0] ext_reg_data_oe_n,
    input wire halt_n,
    input wire reset_pin_n
);
    // --------------------
    // Bus and pin properties
    // --------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire take = core_req && !core_busy;
    // Each access, internal or not, puts its address on the pins.
    a_addr_follows: assert property (take |=> ext_reg_addr == $past(core_addr)) else $error("addr lost");
    a_int_no_strobe: assert property (take && core_int |=> data_strobe_n [*2]) else $error("strobe inside");
    a_idle_strobe: assert property (!core_busy && !core_done |-> data_strobe_n) else $error("idle strobe");
    a_done_release: assert property (core_done |-> data_strobe_n && rd_wr_n) else $error("no release");
    a_write_drives: assert property (!data_strobe_n && !rd_wr_n |-> ext_reg_data_oe_n == 16'h0000)
        else $error("write data floats");
    a_dir_select: assert property (take && !core_int |=> rd_wr_n == !$past(core_we)) else $error("bad dir");
    a_halt_nop: assert property (!halt_n [*5] |-> core_nop_hold) else $error("halt ignored");
    a_run_free: assert property (halt_n [*5] |-> !core_nop_hold) else $error("stuck halted");
    a_push_pc: assert property ($fell(reset_pin_n) |-> ##[1:5] pc_push) else $error("no push");
    a_load_pc: assert property ($rose(reset_pin_n) |-> ##[1:5] pc_load) else $error("no load");
    // Main scenarios reached.
    c_ext_wr: cover property (take && !core_int && core_we);
    c_ext_rd: cover property (take && !core_int && !core_we);
    c_int: cover property (take && core_int);
    c_pin_rst: cover property ($fell(reset_pin_n));
endmodule
`default_nettype wire
